// ### aadcr_map.vh
`ifndef AADCR_MAP_VH
`define AADCR_MAP_VH
// ==================================================
// Register offsets
`define AADCR_ADDR_ROUTE   5'h00
`define AADCR_ADDR_POWER   5'h01
`define AADCR_ADDR_MIXFMT  5'h02
`define AADCR_ADDR_GAIN    5'h03
// ==================================================
// Reset values
`define AADCR_RST_ROUTE    8'h05
`define AADCR_RST_POWER    8'h03
`define AADCR_RST_MIXFMT   8'h30
`define AADCR_RST_GAIN     8'h00
// ==================================================
// Writable bit masks, fixed-zero bits cleared
`define AADCR_MASK_ROUTE   8'h1F
`define AADCR_MASK_POWER   8'h03
`define AADCR_MASK_MIXFMT  8'hF2
`define AADCR_MASK_GAIN    8'hFF
// ==================================================
// Field positions
`define AADCR_BIT_DCBLOCK  4
`define AADCR_BIT_AMPPWR   0
`define AADCR_BIT_CONVPWR  1
`define AADCR_BIT_FORMAT   1
`define AADCR_BIT_ZCEN     7
`define AADCR_MIX_HI       7
`define AADCR_MIX_LO       6
`define AADCR_ZTM_HI       5
`define AADCR_ZTM_LO       4
// ==================================================
// Frame layout and timing counts
`define AADCR_FRAME_BITS   16
`define AADCR_OP_WRITE_BIT 2
`define AADCR_TMO_BASE     12'h100
`define AADCR_GAIN_MAX     7'h60
`endif

// ### aadcr_serial_rx.v
`timescale 1ns/1ps
// ==================================================
// Serial control receiver, oversampled by CLK
module aadcr_serial_rx (
    input  wire       clk,
    input  wire       rstn,
    input  wire       csn_s,
    input  wire       sclk_s,
    input  wire       sdi_s,
    output reg        frame_ok,
    output reg  [4:0] frame_addr,
    output reg  [7:0] frame_data
);
`include "aadcr_map.vh"
    reg  [15:0] shift;      // Bits in arrival order, newest at top
    reg  [4:0]  edges;      // Rising control clock count in frame
    reg         sclk_d;     // Previous sampled control clock
    reg         csn_d;      // Previous sampled select

    // ==================================================
    // Shift on rising control clock, commit on select rise
    always @(posedge clk) begin
        if (!rstn) begin
            shift      <= 16'h0000;
            edges      <= 5'h00;
            sclk_d     <= 1'b1;
            csn_d      <= 1'b1;
            frame_ok   <= 1'b0;
            frame_addr <= 5'h00;
            frame_data <= 8'h00;
        end else begin
            sclk_d   <= sclk_s;
            csn_d    <= csn_s;
            frame_ok <= 1'b0;
            if (!csn_s && sclk_s && !sclk_d) begin
                // Device samples on rising control clock [R18]
                shift <= {sdi_s, shift[15:1]};
                if (edges != 5'h1F)
                    edges <= edges + 5'h01;
            end
            if (csn_s && !csn_d) begin
                // Exactly sixteen edges and a write opcode [R19]
                // Bit order: op0..op2, A0..A4, D0..D7 after shifting right [R18]
                if (edges == `AADCR_FRAME_BITS && shift[`AADCR_OP_WRITE_BIT]) begin
                    frame_ok   <= 1'b1;
                    frame_addr <= shift[7:3];
                    frame_data <= shift[15:8];
                end
                edges <= 5'h00;
            end else if (csn_s) begin
                // Idle select keeps the count cleared
                edges <= 5'h00;
            end
        end
    end
endmodule

// ### aadcr_gain_chan.v
`timescale 1ns/1ps
// ==================================================
// One channel of applied gain with zero-cross tracking
module aadcr_gain_chan (
    input  wire       clk,
    input  wire       rstn,
    input  wire       load_now,
    input  wire       arm,
    input  wire       fs_tick,
    input  wire       zero_cross,
    input  wire       timeout,
    input  wire [6:0] target,
    output reg  [6:0] gain,
    output reg        pending
);
    // ==================================================
    // Applied value moves only on a cause
    always @(posedge clk) begin
        if (!rstn) begin
            gain    <= 7'h00;
            pending <= 1'b0;
        end else if (load_now) begin
            gain    <= target;      // Immediate change [R12]
            pending <= 1'b0;
        end else if (arm) begin
            pending <= 1'b1;        // Keeps current value, aims at new target [R16]
        end else if (pending && fs_tick && (zero_cross || timeout)) begin
            gain    <= target;      // First of crossing or timeout [R11]
            pending <= 1'b0;
        end
    end
endmodule

// ### aadcr_top.v
// Behaviour
// [R1] Low reset pin resets registers, blocks writes
// [R2] Route bit 4 set bypasses DC filter
// [R3] Route bits 3:0 connect four inputs
// [R4] Power bits: amp bit0, converter bit1
// [R5] Pin low or both bits clear: down
// [R6] Host keeps master clock while converter on
// [R7] Mix field picks stereo, average, left, right
// [R8] Timeout field picks 256 to 2048 samples
// [R9] Format bit picks justified or I2S
// [R10] Mix register writes ignored, converter off
// [R11] Zero-cross gain change per channel, timeout
// [R12] No zero-cross or converter off: immediate
// [R13] Seven-bit gain, code zero mutes
// [R14] Gain code steps map to decibels
// [R15] Gain writes ignored while amp off
// [R16] Rewrite restarts counter, channels keep values
// [R17] Host waits a timeout between gain writes
// [R18] Frame: opcode, address, data, LSB first
// [R19] Sixteen edges, commit on select rise
// [R20] Addresses above 03H are refused
// [R21] Host avoids power writes during calibration
// [R22] Fixed-zero bits always stay zero
`timescale 1ns/1ps
module aadcr_top #(
    parameter TMO_W = 12                // Width of the sample timeout limit; the counter has one bit more
) (
    input  wire       CLK,
    input  wire       RSTN,
    input  wire       CONTROL_SELECT_N,
    input  wire       CONTROL_CLOCK,
    input  wire       CONTROL_DATA_IN,
    input  wire       FRAME_CLOCK,
    input  wire       ZERO_CROSS_LEFT,
    input  wire       ZERO_CROSS_RIGHT,
    output reg        DC_BLOCK_FILTER_OFF,
    output reg        LEFT_INPUT_ONE_ON,
    output reg        LEFT_INPUT_TWO_ON,
    output reg        RIGHT_INPUT_ONE_ON,
    output reg        RIGHT_INPUT_TWO_ON,
    output reg        AMP_POWERED,
    output reg        CONVERTER_POWERED,
    output reg  [1:0] CHANNEL_MIX_FIELD,
    output reg  [1:0] LEFT_SOURCE_SEL,
    output reg  [1:0] RIGHT_SOURCE_SEL,
    output reg        OUTPUT_FORMAT_BIT,
    output reg        LEFT_FRAME_LEVEL,
    output reg  [6:0] LEFT_GAIN,
    output reg  [6:0] RIGHT_GAIN,
    output reg        LEFT_MUTE,
    output reg        RIGHT_MUTE,
    output reg        GAIN_PENDING
);
`include "aadcr_map.vh"

    // ==================================================
    // Source select encodings for each output channel
    localparam [1:0] SRC_LEFT  = 2'h0;  // Left channel sample
    localparam [1:0] SRC_RIGHT = 2'h1;  // Right channel sample
    localparam [1:0] SRC_AVG   = 2'h2;  // (L+R)/2

    // ==================================================
    // Synchronisers for pins from outside the CLK domain
    reg  [1:0] csn_sync;                // Select, stage 0 first
    reg  [1:0] sclk_sync;               // Control clock
    reg  [1:0] sdi_sync;                // Control data
    reg  [1:0] lr_sync;                 // Frame clock
    reg  [1:0] zl_sync;                 // Left zero-cross comparator
    reg  [1:0] zr_sync;                 // Right zero-cross comparator
    reg        lr_d;                    // Previous synchronised frame clock

    // Two stages before any logic reads a pin
    always @(posedge CLK) begin
        if (!RSTN) begin
            csn_sync  <= 2'h3;
            sclk_sync <= 2'h3;
            sdi_sync  <= 2'h0;
            lr_sync   <= 2'h0;
            zl_sync   <= 2'h0;
            zr_sync   <= 2'h0;
            lr_d      <= 1'b0;
        end else begin
            csn_sync  <= {csn_sync[0], CONTROL_SELECT_N};
            sclk_sync <= {sclk_sync[0], CONTROL_CLOCK};
            sdi_sync  <= {sdi_sync[0], CONTROL_DATA_IN};
            lr_sync   <= {lr_sync[0], FRAME_CLOCK};
            zl_sync   <= {zl_sync[0], ZERO_CROSS_LEFT};
            zr_sync   <= {zr_sync[0], ZERO_CROSS_RIGHT};
            lr_d      <= lr_sync[1];
        end
    end

    // One pulse per sample period on the frame clock rising edge
    wire fs_tick = lr_sync[1] && !lr_d;

    // ==================================================
    // Serial control port receiver
    wire       frame_ok;                // Valid write frame, one pulse
    wire [4:0] frame_addr;              // Register address
    wire [7:0] frame_data;              // Data byte

    aadcr_serial_rx u_rx (
        .clk        (CLK),
        .rstn       (RSTN),
        .csn_s      (csn_sync[1]),
        .sclk_s     (sclk_sync[1]),
        .sdi_s      (sdi_sync[1]),
        .frame_ok   (frame_ok),
        .frame_addr (frame_addr),
        .frame_data (frame_data)
    );

    // ==================================================
    // Register file, write only
    reg  [7:0] input_routing_select;    // Address 00H
    reg  [7:0] power_control;           // Address 01H
    reg  [7:0] mixing_format_control;   // Address 02H
    reg  [7:0] input_gain_control;      // Address 03H

    wire conv_on = power_control[`AADCR_BIT_CONVPWR];
    wire amp_on  = power_control[`AADCR_BIT_AMPPWR];

    // Decoded write strobes; out-of-range addresses match none [R20]
    wire wr_route = frame_ok && (frame_addr == `AADCR_ADDR_ROUTE);
    wire wr_power = frame_ok && (frame_addr == `AADCR_ADDR_POWER);
    wire wr_mix   = frame_ok && (frame_addr == `AADCR_ADDR_MIXFMT) && conv_on; // [R10]
    wire wr_gain  = frame_ok && (frame_addr == `AADCR_ADDR_GAIN) && amp_on;    // [R15]

    // Synchronous reset loads the reset values and wins over any write [R1]
    always @(posedge CLK) begin
        if (!RSTN) begin
            input_routing_select  <= `AADCR_RST_ROUTE;   // [R1]
            power_control         <= `AADCR_RST_POWER;
            mixing_format_control <= `AADCR_RST_MIXFMT;
            input_gain_control    <= `AADCR_RST_GAIN;
        end else begin
            // Masks keep fixed-zero positions at zero [R22]
            if (wr_route)
                input_routing_select <= frame_data & `AADCR_MASK_ROUTE;
            // Clearing both power bits keeps all other contents [R5]
            if (wr_power)
                power_control <= frame_data & `AADCR_MASK_POWER;
            if (wr_mix)
                mixing_format_control <= frame_data & `AADCR_MASK_MIXFMT;
            if (wr_gain)
                input_gain_control <= frame_data & `AADCR_MASK_GAIN;
        end
    end

    // ==================================================
    // Zero-cross timeout: 256 sample periods shifted by the field [R8]
    function [TMO_W-1:0] tmo_limit;
        input [1:0] sel;
        begin
            tmo_limit = `AADCR_TMO_BASE << sel;
        end
    endfunction

    // Clamp out-of-range codes; the table stops at the top code [R14]
    function [6:0] gain_clamp;
        input [6:0] code;
        begin
            gain_clamp = (code > `AADCR_GAIN_MAX) ? `AADCR_GAIN_MAX : code;
        end
    endfunction

    // Converter off forces zero-cross off whatever is stored [R12]
    wire       zc_active = input_gain_control[`AADCR_BIT_ZCEN] && conv_on;
    wire [6:0] gain_tgt  = gain_clamp(input_gain_control[6:0]);
    reg        gain_wr_d;               // Write seen last cycle, register now holds it
    reg  [TMO_W:0] tmo_cnt;             // Sample periods since the last gain write
    wire       any_pending;
    wire       tmo_hit = (tmo_cnt[TMO_W-1:0] ==
                          tmo_limit(mixing_format_control[`AADCR_ZTM_HI:`AADCR_ZTM_LO]) - 1'b1)
                          && fs_tick;

    // Counter restarts on every new gain write [R16]
    always @(posedge CLK) begin
        if (!RSTN) begin
            gain_wr_d <= 1'b0;
            tmo_cnt   <= {(TMO_W+1){1'b0}};
        end else begin
            gain_wr_d <= wr_gain;
            if (gain_wr_d)
                tmo_cnt <= {(TMO_W+1){1'b0}};   // [R16]
            else if (any_pending && fs_tick)
                tmo_cnt <= tmo_cnt + 1'b1;
        end
    end

    // ==================================================
    // Independent per-channel applied gain [R11]
    wire [6:0] gain_l;
    wire [6:0] gain_r;
    wire       pend_l;
    wire       pend_r;
    assign any_pending = pend_l || pend_r;

    aadcr_gain_chan u_left (
        .clk        (CLK),
        .rstn       (RSTN),
        .load_now   (gain_wr_d && !zc_active),
        .arm        (gain_wr_d && zc_active),
        .fs_tick    (fs_tick),
        .zero_cross (zl_sync[1]),
        .timeout    (tmo_hit),
        .target     (gain_tgt),
        .gain       (gain_l),
        .pending    (pend_l)
    );

    aadcr_gain_chan u_right (
        .clk        (CLK),
        .rstn       (RSTN),
        .load_now   (gain_wr_d && !zc_active),
        .arm        (gain_wr_d && zc_active),
        .fs_tick    (fs_tick),
        .zero_cross (zr_sync[1]),
        .timeout    (tmo_hit),
        .target     (gain_tgt),
        .gain       (gain_r),
        .pending    (pend_r)
    );

    // ==================================================
    // Mixing source select from the two-bit field [R7]
    reg  [1:0] next_left_src;
    reg  [1:0] next_right_src;
    always @* begin
        case (mixing_format_control[`AADCR_MIX_HI:`AADCR_MIX_LO])
            2'h0: begin
                next_left_src  = SRC_LEFT;     // Stereo
                next_right_src = SRC_RIGHT;
            end
            2'h1: begin
                next_left_src  = SRC_AVG;      // Average on both
                next_right_src = SRC_AVG;
            end
            2'h2: begin
                next_left_src  = SRC_LEFT;     // Left on both
                next_right_src = SRC_LEFT;
            end
            default: begin
                next_left_src  = SRC_RIGHT;    // Right on both
                next_right_src = SRC_RIGHT;
            end
        endcase
    end

    // ==================================================
    // Registered outputs; pin low also powers everything down [R5]
    wire all_down = !RSTN || (!amp_on && !conv_on);
    always @(posedge CLK) begin
        if (!RSTN) begin
            DC_BLOCK_FILTER_OFF <= 1'b0;
            LEFT_INPUT_ONE_ON   <= 1'b1;
            LEFT_INPUT_TWO_ON   <= 1'b0;
            RIGHT_INPUT_ONE_ON  <= 1'b1;
            RIGHT_INPUT_TWO_ON  <= 1'b0;
            AMP_POWERED         <= 1'b0;       // [R5]
            CONVERTER_POWERED   <= 1'b0;
            CHANNEL_MIX_FIELD   <= 2'h0;
            LEFT_SOURCE_SEL     <= SRC_LEFT;
            RIGHT_SOURCE_SEL    <= SRC_RIGHT;
            OUTPUT_FORMAT_BIT   <= 1'b0;
            LEFT_FRAME_LEVEL    <= 1'b1;
            LEFT_GAIN           <= 7'h00;
            RIGHT_GAIN          <= 7'h00;
            LEFT_MUTE           <= 1'b1;
            RIGHT_MUTE          <= 1'b1;
            GAIN_PENDING        <= 1'b0;
        end else begin
            // Zero enables the DC filter, one bypasses it [R2]
            DC_BLOCK_FILTER_OFF <= input_routing_select[`AADCR_BIT_DCBLOCK];
            LEFT_INPUT_ONE_ON   <= input_routing_select[0];   // [R3]
            LEFT_INPUT_TWO_ON   <= input_routing_select[1];
            RIGHT_INPUT_ONE_ON  <= input_routing_select[2];
            RIGHT_INPUT_TWO_ON  <= input_routing_select[3];
            AMP_POWERED         <= amp_on && !all_down;      // [R4]
            CONVERTER_POWERED   <= conv_on && !all_down;     // [R4]
            CHANNEL_MIX_FIELD   <= mixing_format_control[`AADCR_MIX_HI:`AADCR_MIX_LO];
            LEFT_SOURCE_SEL     <= next_left_src;            // [R7]
            RIGHT_SOURCE_SEL    <= next_right_src;
            // Zero: justified, left on high; one: I2S, left on low [R9]
            OUTPUT_FORMAT_BIT   <= mixing_format_control[`AADCR_BIT_FORMAT];
            LEFT_FRAME_LEVEL    <= !mixing_format_control[`AADCR_BIT_FORMAT];
            LEFT_GAIN           <= gain_l;
            RIGHT_GAIN          <= gain_r;
            // Code zero mutes the amplifier [R13]
            LEFT_MUTE           <= (gain_l == 7'h00);
            RIGHT_MUTE          <= (gain_r == 7'h00);
            GAIN_PENDING        <= any_pending;
        end
    end
endmodule

// ### aadcr_checker_assertions.sv
`timescale 1ns/1ps
// ==================================================
// Port checker for the control register bank
module aadcr_checker (
    input wire       CLK,
    input wire       RSTN,
    input wire       CONTROL_SELECT_N,
    input wire       FRAME_CLOCK,
    input wire       DC_BLOCK_FILTER_OFF,
    input wire       LEFT_INPUT_ONE_ON,
    input wire       RIGHT_INPUT_ONE_ON,
    input wire       AMP_POWERED,
    input wire       CONVERTER_POWERED,
    input wire [1:0] CHANNEL_MIX_FIELD,
    input wire [1:0] LEFT_SOURCE_SEL,
    input wire [1:0] RIGHT_SOURCE_SEL,
    input wire       OUTPUT_FORMAT_BIT,
    input wire       LEFT_FRAME_LEVEL,
    input wire [6:0] LEFT_GAIN,
    input wire [6:0] RIGHT_GAIN,
    input wire       LEFT_MUTE,
    input wire       RIGHT_MUTE
);
    default clocking cb @(posedge CLK);
    endclocking
    reg [3:0] since_sel;  // Edges since select rose, saturating
    reg [3:0] since_fs;   // Edges since frame clock rose, saturating
    // ==================================================
    // Age counters on raw pins; sync delay fits the windows
    always @(posedge CLK) begin
        if (!RSTN)
            since_sel <= 4'hF;
        else if ($rose(CONTROL_SELECT_N))
            since_sel <= 4'h0;
        else if (since_sel != 4'hF)
            since_sel <= since_sel + 4'h1;
        if (!RSTN)
            since_fs <= 4'hF;
        else if ($rose(FRAME_CLOCK))
            since_fs <= 4'h0;
        else if (since_fs != 4'hF)
            since_fs <= since_fs + 4'h1;
    end
    // ==================================================
    // Properties
    property p_reset_values;
        !RSTN ##1 !RSTN |-> !DC_BLOCK_FILTER_OFF && LEFT_INPUT_ONE_ON && RIGHT_INPUT_ONE_ON
            && !AMP_POWERED && !CONVERTER_POWERED && CHANNEL_MIX_FIELD == 2'b00
            && !OUTPUT_FORMAT_BIT && LEFT_GAIN == 7'h00 && RIGHT_GAIN == 7'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
    property p_mute;
        disable iff (!RSTN) LEFT_MUTE == (LEFT_GAIN == 7'h00) && RIGHT_MUTE == (RIGHT_GAIN == 7'h00);
    endproperty
    a_mute: assert property (p_mute) else $error("mute does not follow gain");
    property p_format;
        disable iff (!RSTN) LEFT_FRAME_LEVEL != OUTPUT_FORMAT_BIT;
    endproperty
    a_format: assert property (p_format) else $error("frame level wrong");
    property p_source;
        disable iff (!RSTN) {LEFT_SOURCE_SEL, RIGHT_SOURCE_SEL} ==
            (CHANNEL_MIX_FIELD == 2'b00 ? 4'h1 : CHANNEL_MIX_FIELD == 2'b01 ? 4'hA :
             CHANNEL_MIX_FIELD == 2'b10 ? 4'h0 : 4'h5);
    endproperty
    a_source: assert property (p_source) else $error("source select wrong");
    property p_cfg_change;
        disable iff (!RSTN) !$stable({DC_BLOCK_FILTER_OFF, LEFT_INPUT_ONE_ON, RIGHT_INPUT_ONE_ON,
            CHANNEL_MIX_FIELD, OUTPUT_FORMAT_BIT}) |-> since_sel >= 4'h2 && since_sel <= 4'h8;
    endproperty
    a_cfg_change: assert property (p_cfg_change) else $error("config moved off a frame");
    property p_pwr_change;
        disable iff (!RSTN) !$stable({AMP_POWERED, CONVERTER_POWERED}) |->
            (since_sel >= 4'h2 && since_sel <= 4'h8) || !$past(RSTN) || !$past(RSTN, 2);
    endproperty
    a_pwr_change: assert property (p_pwr_change) else $error("power moved off a frame");
    property p_gain_change;
        disable iff (!RSTN) !$stable({LEFT_GAIN, RIGHT_GAIN}) |->
            (since_sel >= 4'h2 && since_sel <= 4'h9) || since_fs <= 4'h8;
    endproperty
    a_gain_change: assert property (p_gain_change) else $error("gain moved off a tick");
    property p_gain_clamp;
        disable iff (!RSTN) LEFT_GAIN <= 7'h60 && RIGHT_GAIN <= 7'h60;
    endproperty
    a_gain_clamp: assert property (p_gain_clamp) else $error("gain above top code");
endmodule
bind aadcr_top aadcr_checker u_aadcr_checker (
    .CLK(CLK), .RSTN(RSTN), .CONTROL_SELECT_N(CONTROL_SELECT_N), .FRAME_CLOCK(FRAME_CLOCK),
    .DC_BLOCK_FILTER_OFF(DC_BLOCK_FILTER_OFF), .LEFT_INPUT_ONE_ON(LEFT_INPUT_ONE_ON),
    .RIGHT_INPUT_ONE_ON(RIGHT_INPUT_ONE_ON), .AMP_POWERED(AMP_POWERED),
    .CONVERTER_POWERED(CONVERTER_POWERED), .CHANNEL_MIX_FIELD(CHANNEL_MIX_FIELD),
    .LEFT_SOURCE_SEL(LEFT_SOURCE_SEL), .RIGHT_SOURCE_SEL(RIGHT_SOURCE_SEL),
    .OUTPUT_FORMAT_BIT(OUTPUT_FORMAT_BIT), .LEFT_FRAME_LEVEL(LEFT_FRAME_LEVEL),
    .LEFT_GAIN(LEFT_GAIN), .RIGHT_GAIN(RIGHT_GAIN), .LEFT_MUTE(LEFT_MUTE), .RIGHT_MUTE(RIGHT_MUTE)
);

// ### aadcr_host_model.sv
`timescale 1ns/1ps
// ==================================================
// Host side of the three-wire control port
module aadcr_host_model (
    input  wire clk,   // Pacing clock only
    output reg  control_select_n,   // Select, idle high
    output reg  sclk,  // Serial clock, still between frames
    output reg  sdi    // Serial data
);
    localparam HALF = 4;  // 400 ns half period of the serial clock
    initial begin
        control_select_n  = 1'b1;
        sclk = 1'b1;
        sdi  = 1'b0;
    end
    // Wait n rising edges of the pacing clock
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // One frame of nbits bits; short counts model a broken host
    task send(input [2:0] op, input [4:0] addr, input [7:0] data, input integer nbits);
        reg [15:0] word;
        integer    i;
        word = {data, addr, op};
        control_select_n <= 1'b0;
        tick(HALF);
        for (i = 0; i < nbits; i = i + 1) begin
            sclk <= 1'b0;
            sdi  <= word[i];
            tick(HALF);
            sclk <= 1'b1;
            tick(HALF);
        end
        control_select_n <= 1'b1;
        tick(HALF);
        // Released line must not keep the last bit
        sdi <= ~sdi;
        tick(3 * HALF);
    endtask
endmodule

// ### aadcr_top_tb.sv
`timescale 1ns/1ps
// ==================================================
// Register bank testbench
module aadcr_top_tb;
    reg         clk;       // 10 MHz system clock
    reg         rstn = 1'b0;    // Reset and power-down pin
    reg         fs_clk = 1'b0;  // Frame clock, one tick per 16 CLK
    reg  [1:0]  zc = 2'b00;     // Crossing comparators, right and left
    reg  [3:0]  fs_cnt = 4'h0;  // Frame clock divider
    integer     cycles = 0;     // Hang guard
    integer     n_mismatch = 0;
    integer     cmp_count = 0;
    integer     k;
    wire        control_select_n;
    wire        sclk;
    wire        sdi;
    wire [15:0] route;     // Route outputs in register bit order
    wire [15:0] pwr;       // Converter, amp
    wire [15:0] mixv;      // Mix, sources, format, frame level
    wire [15:0] gains;     // Left and right applied gain
    wire [15:0] stat;      // Mutes and pending
    assign route[15:5] = 11'h000;
    assign pwr[15:2]   = 14'h0000;
    assign mixv[15:8]  = 8'h00;
    assign gains[15:14] = 2'b00;
    assign stat[15:3]  = 13'h0000;
    aadcr_host_model u_aadcr_host_model (.clk(clk), .control_select_n(control_select_n), .sclk(sclk), .sdi(sdi));
    aadcr_top u_aadcr_top (
        .CLK(clk), .RSTN(rstn), .CONTROL_SELECT_N(control_select_n), .CONTROL_CLOCK(sclk),
        .CONTROL_DATA_IN(sdi), .FRAME_CLOCK(fs_clk), .ZERO_CROSS_LEFT(zc[0]),
        .ZERO_CROSS_RIGHT(zc[1]), .DC_BLOCK_FILTER_OFF(route[4]), .RIGHT_INPUT_TWO_ON(route[3]),
        .RIGHT_INPUT_ONE_ON(route[2]), .LEFT_INPUT_TWO_ON(route[1]), .LEFT_INPUT_ONE_ON(route[0]),
        .CONVERTER_POWERED(pwr[1]), .AMP_POWERED(pwr[0]), .CHANNEL_MIX_FIELD(mixv[7:6]),
        .LEFT_SOURCE_SEL(mixv[5:4]), .RIGHT_SOURCE_SEL(mixv[3:2]), .OUTPUT_FORMAT_BIT(mixv[1]),
        .LEFT_FRAME_LEVEL(mixv[0]), .LEFT_GAIN(gains[13:7]), .RIGHT_GAIN(gains[6:0]),
        .LEFT_MUTE(stat[2]), .RIGHT_MUTE(stat[1]), .GAIN_PENDING(stat[0])
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Free-running frame clock and the hang guard
    always @(posedge clk) begin
        fs_cnt <= fs_cnt + 4'h1;
        fs_clk <= fs_cnt[3];
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    // ==================================================
    // Tasks
    task wr(input [4:0] a, input [7:0] d);
        u_aadcr_host_model.send(3'b100, a, d, 16);
    endtask
    task compare(input [15:0] got, input [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected mix outputs: sources 0 left, 1 right, 2 average
    function [15:0] mix_exp(input [1:0] m, input f);
        mix_exp = {8'h00, m, ((m == 2'b00) ? 4'h1 : (m == 2'b01) ? 4'hA :
                              (m == 2'b10) ? 4'h0 : 4'h5), f, ~f};
    endfunction
    function [15:0] gv(input [6:0] l, input [6:0] r);
        gv = {2'b00, l, r};
    endfunction
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        compare(route, 16'h0005);
        compare(pwr, 16'h0000);
        compare(mixv, mix_exp(2'b00, 1'b0));
        compare(stat, 16'h0006);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        compare(pwr, 16'h0003);
        $display("reset test done");
        wr(5'h00, 8'hFF);
        compare(route, 16'h001F);
        wr(5'h00, 8'h0A);
        compare(route, 16'h000A);
        wr(5'h00, 8'h10);
        compare(route, 16'h0010);
        $display("route test done");
        wr(5'h04, 8'h00);
        compare(route, 16'h0010);
        wr(5'h1F, 8'h00);
        compare(route, 16'h0010);
        u_aadcr_host_model.send(3'b011, 5'h00, 8'h00, 16);
        compare(route, 16'h0010);
        u_aadcr_host_model.send(3'b100, 5'h00, 8'h00, 15);
        compare(route, 16'h0010);
        $display("refusal test done");
        for (k = 0; k < 8; k = k + 1) begin
            wr(5'h02, {k[2:1], 4'hC, k[0], 1'b0});
            compare(mixv, mix_exp(k[2:1], k[0]));
        end
        $display("mix test done");
        wr(5'h03, 8'h45);
        compare(gains, gv(7'h45, 7'h45));
        compare(stat, 16'h0000);
        wr(5'h03, 8'h7F);
        compare(gains, gv(7'h60, 7'h60));
        wr(5'h03, 8'h00);
        compare(stat, 16'h0006);
        $display("gain test done");
        // Shortest timeout, 256 ticks
        wr(5'h02, 8'h00);
        wr(5'h03, 8'h30);
        wr(5'h03, 8'hB1);
        compare(gains, gv(7'h30, 7'h30));
        compare(stat, 16'h0001);
        zc <= 2'b01;
        repeat (48) @(posedge clk);
        zc <= 2'b00;
        compare(gains, gv(7'h31, 7'h30));
        // Rewrite while right waits restarts the count
        wr(5'h03, 8'hB2);
        repeat (3950) @(posedge clk);
        compare(gains, gv(7'h31, 7'h30));
        compare(stat, 16'h0001);
        repeat (300) @(posedge clk);
        compare(gains, gv(7'h32, 7'h32));
        compare(stat, 16'h0000);
        wr(5'h03, 8'hB3);
        zc <= 2'b10;
        repeat (48) @(posedge clk);
        zc <= 2'b00;
        compare(gains, gv(7'h32, 7'h33));
        $display("zero cross test done");
        wr(5'h01, 8'h01);
        compare(pwr, 16'h0001);
        wr(5'h02, 8'hC2);
        compare(mixv, mix_exp(2'b00, 1'b0));
        wr(5'h03, 8'hA0);
        compare(gains, gv(7'h20, 7'h20));
        compare(stat, 16'h0000);
        wr(5'h01, 8'h00);
        compare(pwr, 16'h0000);
        wr(5'h03, 8'h10);
        compare(gains, gv(7'h20, 7'h20));
        wr(5'h00, 8'h03);
        compare(route, 16'h0003);
        wr(5'h01, 8'h03);
        compare(pwr, 16'h0003);
        compare(mixv, mix_exp(2'b00, 1'b0));
        $display("power test done");
        rstn <= 1'b0;
        wr(5'h00, 8'h1F);
        compare(route, 16'h0005);
        compare(gains, gv(7'h00, 7'h00));
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        compare(route, 16'h0005);
        $display("mid-run reset test done");
        close_out;
    end
endmodule
